// ---- scd_decoder.sv ----
// Servo link command decoder with AXI4-Lite register access
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "scd_regs.svh"

module scd_decoder (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output scd_pkg::scd_ext_t ext_rd_kind,
  output logic [4:0]       ext_rd_index,
  input  wire logic [31:0] ext_rd_data,
  input  wire logic [31:0] current_position,
  input  wire logic        latch_position_input,
  input  wire logic        latch_position_instruction,
  output logic             status_clear,
  output logic             alarm_history_clear,
  output logic             alarm_reset,
  output logic             param_write,
  output logic [3:0]       param_group,
  output logic [7:0]       param_number,
  output logic [31:0]      param_value,
  output logic             input_dev_write,
  output logic [7:0]       input_dev_number,
  output logic [31:0]      input_dev_value
);

  // ****************************************
  // Helper functions
  // ****************************************

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // Inclusive range check on a data number
  function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo, input logic [7:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction

  // Exact key match, upper half must be clear too
  function automatic logic key_ok(input logic [31:0] v);
    return v == `SCD_KEY;
  endfunction

  // ****************************************
  // State
  // ****************************************
  scd_pkg::scd_state_t q;    // Registered state
  scd_pkg::scd_state_t d;    // Next state
  logic [7:0]          cmd;  // Command code under execution
  logic [7:0]          dno;  // Data number under execution
  logic                prog; // Program mode selected
  logic [31:0]         mode_word;

  assign cmd  = q.cmd[`SCD_CMD_CODE];
  assign dno  = q.cmd[`SCD_CMD_DNO];
  assign prog = q.mode[`SCD_MODE_PROG];
  assign mode_word = {17'h00000, q.mode};

  // ****************************************
  // Handshakes and outputs
  // ****************************************
  // One write at a time; the response blocks a new address
  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready  = !q.w_got && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign status_clear        = q.ev_stat_clr;
  assign alarm_history_clear = q.ev_alm_hist;
  assign alarm_reset         = q.ev_alm_rst;
  assign param_write         = q.ev_param;
  assign param_group         = q.group;
  assign param_number        = q.ev_index;
  assign param_value         = q.ev_data;
  assign input_dev_write     = q.ev_in_dev;
  assign input_dev_number    = q.ev_index;
  assign input_dev_value     = q.ev_data;
  assign ext_rd_index        = dno[4:0];

  // Lookup select follows the held command; the answer is used in the execute cycle
  always_comb
  begin
    unique case (cmd)
      `SCD_C_PT_POS:   ext_rd_kind = scd_pkg::SCD_EXT_PT_POS;
      `SCD_C_PT_SPEED: ext_rd_kind = scd_pkg::SCD_EXT_PT_SPEED;
      `SCD_C_PT_ACC:   ext_rd_kind = scd_pkg::SCD_EXT_PT_ACC;
      `SCD_C_PT_DEC:   ext_rd_kind = scd_pkg::SCD_EXT_PT_DEC;
      `SCD_C_PT_DWELL: ext_rd_kind = scd_pkg::SCD_EXT_PT_DWELL;
      `SCD_C_PT_AUX:   ext_rd_kind = scd_pkg::SCD_EXT_PT_AUX;
      `SCD_C_GP_R:     ext_rd_kind = scd_pkg::SCD_EXT_GP_R;
      `SCD_C_GP_D:     ext_rd_kind = scd_pkg::SCD_EXT_GP_D;
      `SCD_C_ABS:      ext_rd_kind = (dno == `SCD_D_ABS_CMD) ? scd_pkg::SCD_EXT_ABS_CMD
                                                            : scd_pkg::SCD_EXT_ABS_PLS;
      default:         ext_rd_kind = scd_pkg::SCD_EXT_NONE;
    endcase
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    scd_pkg::scd_res_t res;
    logic [4:0]        len;
    logic [31:0]       rep;
    logic [31:0]       m;
    res = scd_pkg::SCD_RES_OK;
    len = `SCD_LEN_4;
    rep = 32'h00000000;
    m   = 32'h00000000;
    d   = q;
    // Events last one cycle
    d.ev_stat_clr = 1'b0;
    d.ev_alm_hist = 1'b0;
    d.ev_alm_rst  = 1'b0;
    d.ev_param    = 1'b0;
    d.ev_in_dev   = 1'b0;

    // Position capture on the rising latch input while the instruction runs
    d.latch_prev = latch_position_input;
    if (latch_position_input && !q.latch_prev && latch_position_instruction)
      d.latch_pos = {{16{current_position[31]}}, current_position};

    // Write address and data may come in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      d.aw_got  = 1'b1;
      d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      d.w_got  = 1'b1;
      d.w_data = s_axi_wdata;
      d.w_strb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready)
      d.bvalid = 1'b0;

    // Register write; held off while a command executes so the command word stays stable
    if (q.aw_got && q.w_got && !q.bvalid && q.fsm == scd_pkg::SCD_IDLE)
    begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = `SCD_RESP_OKAY;
      case (q.aw_addr)
        `SCD_OFF_CMD:
        begin
          // Writing the command word launches it
          m      = merge({16'h0000, q.cmd}, q.w_data, q.w_strb);
          d.cmd  = m[15:0];
          d.fsm  = scd_pkg::SCD_EXEC;
          d.done = 1'b0;
        end
        `SCD_OFF_DATA:
          d.wr_data = merge(q.wr_data, q.w_data, q.w_strb);
        `SCD_OFF_MODE:
        begin
          m      = merge(mode_word, q.w_data, q.w_strb);
          d.mode = m[14:0];
        end
        // Read-only words ignore writes
        `SCD_OFF_STATUS, `SCD_OFF_REPLY_LO, `SCD_OFF_REPLY_HI: ;
        default:
          d.bresp = `SCD_RESP_SLVERR;
      endcase
    end

    // Register read, unmapped reads answer zero with an error
    if (q.rvalid && s_axi_rready)
      d.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      d.rvalid = 1'b1;
      d.rresp  = `SCD_RESP_OKAY;
      case (s_axi_araddr)
        `SCD_OFF_CMD:      d.rdata = {16'h0000, q.cmd};
        `SCD_OFF_DATA:     d.rdata = q.wr_data;
        `SCD_OFF_MODE:     d.rdata = mode_word;
        `SCD_OFF_STATUS:   d.rdata = {8'h00, q.group, 3'h0, q.group_valid, 3'h0, q.frame_len,
                                      1'b0, q.result, 2'h0, q.done, q.fsm == scd_pkg::SCD_EXEC};
        `SCD_OFF_REPLY_LO: d.rdata = q.reply_lo;
        `SCD_OFF_REPLY_HI: d.rdata = {16'h0000, q.reply_hi};
        default:
        begin
          d.rdata = 32'h00000000;
          d.rresp = `SCD_RESP_SLVERR;
        end
      endcase
    end

    // Command execution, one cycle
    if (q.fsm == scd_pkg::SCD_EXEC)
    begin
      case (cmd)
        // Table reads, point-table mode only
        `SCD_C_PT_POS, `SCD_C_PT_SPEED, `SCD_C_PT_ACC, `SCD_C_PT_DEC, `SCD_C_PT_DWELL, `SCD_C_PT_AUX:
        begin
          if (!in_range(dno, `SCD_D_01, `SCD_D_PT_LAST))
            res = scd_pkg::SCD_RES_DATA;
          else if (prog)
            res = scd_pkg::SCD_RES_MODE;
          else
          begin
            rep = ext_rd_data;
            len = `SCD_LEN_8;
          end
        end
        `SCD_C_PT_MCODE:
          res = scd_pkg::SCD_RES_RESERVED;
        `SCD_C_UNIT:
        begin
          if (dno == `SCD_D_00)
            rep = {24'h000000, 3'h0, q.mode[`SCD_MODE_UNIT_DIS], 2'h0, q.mode[`SCD_MODE_UNIT]};
          else if (dno != `SCD_D_01)
            res = scd_pkg::SCD_RES_DATA;
          else if (!prog)
            res = scd_pkg::SCD_RES_MODE;
          else
          begin
            rep = q.latch_pos[31:0];
            len = `SCD_LEN_12;
          end
        end
        `SCD_C_GP_R, `SCD_C_GP_D:
        begin
          if (!in_range(dno, `SCD_D_01, `SCD_D_GP_LAST))
            res = scd_pkg::SCD_RES_DATA;
          else if (!prog)
            res = scd_pkg::SCD_RES_MODE;
          else
          begin
            rep = ext_rd_data;
            len = `SCD_LEN_8;
          end
        end
        `SCD_C_GP_NUM:
        begin
          if (dno > `SCD_D_01)
            res = scd_pkg::SCD_RES_DATA;
          else if (!prog)
            res = scd_pkg::SCD_RES_MODE;
          else
          begin
            rep = `SCD_GP_COUNT;
            len = `SCD_LEN_8;
          end
        end
        `SCD_C_OTHERS:
        begin
          if (dno == `SCD_D_TEST)
            rep = {29'h00000000, q.mode[`SCD_MODE_TEST]};
          else if (dno == `SCD_D_STORED)
            rep = {30'h00000000, q.mode[`SCD_MODE_STORED]};
          else if (dno == `SCD_D_CTRL)
            rep = prog ? `SCD_CTRL_PROG : `SCD_CTRL_PT;
          else
            res = scd_pkg::SCD_RES_DATA;
        end
        `SCD_C_ABS:
        begin
          if (dno == `SCD_D_ABS_PLS || dno == `SCD_D_ABS_CMD)
          begin
            rep = ext_rd_data;
            len = `SCD_LEN_8;
          end
          else
            res = scd_pkg::SCD_RES_DATA;
        end
        `SCD_C_STAT_CLR:
        begin
          if (dno != `SCD_D_00)
            res = scd_pkg::SCD_RES_DATA;
          else if (!key_ok(q.wr_data))
            res = scd_pkg::SCD_RES_KEY;
          else
            d.ev_stat_clr = 1'b1;
        end
        `SCD_C_GROUP:
        begin
          // Group values 0-5 and the positioning group only
          if (dno == `SCD_D_00 && (q.wr_data <= `SCD_GRP_LAST || q.wr_data == `SCD_GRP_POS))
          begin
            d.group       = q.wr_data[3:0];
            d.group_valid = 1'b1;
          end
          else
            res = scd_pkg::SCD_RES_DATA;
        end
        `SCD_C_PARAM:
        begin
          len = `SCD_LEN_12;
          if (!in_range(dno, `SCD_D_01, `SCD_D_PARAM_LAST))
            res = scd_pkg::SCD_RES_DATA;
          else if (!q.group_valid)
            res = scd_pkg::SCD_RES_NO_GROUP;
          else
          begin
            d.ev_param = 1'b1;
            d.ev_index = dno;
            d.ev_data  = q.wr_data;
          end
        end
        `SCD_C_IN_DEV:
        begin
          len = `SCD_LEN_8;
          if (in_range(dno, `SCD_D_IN_FIRST, `SCD_D_IN_LAST))
          begin
            d.ev_in_dev = 1'b1;
            d.ev_index  = dno;
            d.ev_data   = q.wr_data;
          end
          else
            res = scd_pkg::SCD_RES_DATA;
        end
        `SCD_C_ALARM:
        begin
          if (dno != `SCD_D_ALM_HIST && dno != `SCD_D_00)
            res = scd_pkg::SCD_RES_DATA;
          else if (!key_ok(q.wr_data))
            res = scd_pkg::SCD_RES_KEY;
          else if (dno == `SCD_D_ALM_HIST)
            d.ev_alm_hist = 1'b1;
          else
            d.ev_alm_rst = 1'b1;
        end
        default:
          res = scd_pkg::SCD_RES_UNKNOWN;
      endcase
      // Reply only kept for a successful command
      d.result    = res;
      d.frame_len = len;
      d.reply_lo  = (res == scd_pkg::SCD_RES_OK) ? rep : 32'h00000000;
      d.reply_hi  = (res == scd_pkg::SCD_RES_OK && len == `SCD_LEN_12 && cmd == `SCD_C_UNIT)
                    ? q.latch_pos[47:32] : 16'h0000;
      d.done      = 1'b1;
      d.fsm       = scd_pkg::SCD_IDLE;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      q <= '0;
    else
      q <= d;
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic exec;
  assign exec = q.fsm == scd_pkg::SCD_EXEC;

  pt_pos_read_a: assert property (
    exec && cmd == `SCD_C_PT_POS && in_range(dno, `SCD_D_01, `SCD_D_PT_LAST) && !prog
    |=> q.frame_len == `SCD_LEN_8 && q.reply_lo == $past(ext_rd_data) && q.done)
    else $error("point table position read wrong");
  mcode_reserved_a: assert property (
    exec && cmd == `SCD_C_PT_MCODE |=> q.result == scd_pkg::SCD_RES_RESERVED)
    else $error("reserved read not flagged");
  pt_field_kind_a: assert property (
    exec && cmd == `SCD_C_PT_DWELL |-> ext_rd_kind == scd_pkg::SCD_EXT_PT_DWELL)
    else $error("dwell lookup not selected");
  pt_range_a: assert property (
    exec && cmd == `SCD_C_PT_SPEED && dno > `SCD_D_PT_LAST |=> q.result == scd_pkg::SCD_RES_DATA)
    else $error("table entry out of range accepted");
  unit_reply_a: assert property (
    exec && cmd == `SCD_C_UNIT && dno == `SCD_D_00
    |=> q.reply_lo[1:0] == $past(q.mode[`SCD_MODE_UNIT]) && q.frame_len == `SCD_LEN_4)
    else $error("unit reply wrong");
  latch_capture_a: assert property (
    latch_position_input && !q.latch_prev && latch_position_instruction
    |=> q.latch_pos[31:0] == $past(current_position))
    else $error("latched position not captured");
  mode_refuse_a: assert property (
    exec && (cmd == `SCD_C_GP_R || cmd == `SCD_C_GP_D) && in_range(dno, `SCD_D_01, `SCD_D_GP_LAST) && !prog
    |=> q.result == scd_pkg::SCD_RES_MODE && q.reply_lo == 32'h00000000)
    else $error("register read served outside program mode");
  ctrl_mode_a: assert property (
    exec && cmd == `SCD_C_OTHERS && dno == `SCD_D_CTRL |=> q.reply_lo == ($past(prog) ? 32'h7 : 32'h6))
    else $error("control mode reply wrong");
  key_event_a: assert property (
    status_clear || alarm_history_clear || alarm_reset |-> q.wr_data == `SCD_KEY ##1 !status_clear)
    else $error("keyed event without key");
  bad_key_a: assert property (
    exec && (cmd == `SCD_C_ALARM || cmd == `SCD_C_STAT_CLR) && !key_ok(q.wr_data)
    |=> !status_clear && !alarm_reset && !alarm_history_clear)
    else $error("keyed write acted on wrong key");
  param_group_a: assert property (
    param_write |-> q.group_valid && param_number != 8'h00)
    else $error("parameter write without group");
  group_sel_a: assert property (
    exec && cmd == `SCD_C_GROUP && dno == `SCD_D_00 && q.wr_data == `SCD_GRP_POS |=> q.group == 4'hC)
    else $error("positioning group not selected");

  param_cov_c:   cover property (param_write);
  alarm_cov_c:   cover property (alarm_reset);
  refused_cov_c: cover property (exec ##1 q.result == scd_pkg::SCD_RES_MODE);

endmodule
`default_nettype wire

// ---- scd_lookup_model.sv ----
// Model of the servo internal values that the decoder looks up
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// Lookup model
// ****************************************
module scd_lookup_model (
  input  wire scd_pkg::scd_ext_t kind,
  input  wire logic [4:0]        index,
  output logic [31:0]            data
);
  // One distinct word per item and entry, so a wrong select or entry shows
  always_comb data = {8'hC3, 4'(kind), 15'h0000, index};
endmodule
`default_nettype wire

// ---- scd_pkg.sv ----
// Types of the servo command decoder
`default_nettype none
package scd_pkg;

  // Decoder sequence, Gray coded
  typedef enum logic [1:0] {SCD_IDLE = 2'b00, SCD_EXEC = 2'b01} scd_fsm_t;

  // Which internal value the lookup port is asked for
  typedef enum logic [3:0] {
    SCD_EXT_NONE, SCD_EXT_PT_POS, SCD_EXT_PT_SPEED, SCD_EXT_PT_ACC, SCD_EXT_PT_DEC,
    SCD_EXT_PT_DWELL, SCD_EXT_PT_AUX, SCD_EXT_GP_R, SCD_EXT_GP_D, SCD_EXT_ABS_PLS, SCD_EXT_ABS_CMD
  } scd_ext_t;

  // Outcome of the last command
  typedef enum logic [2:0] {
    SCD_RES_OK, SCD_RES_MODE, SCD_RES_KEY, SCD_RES_DATA, SCD_RES_UNKNOWN, SCD_RES_RESERVED, SCD_RES_NO_GROUP
  } scd_res_t;

  // Whole state of the decoder
  typedef struct packed {
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    scd_fsm_t    fsm;
    logic [15:0] cmd;
    logic [31:0] wr_data;
    logic [14:0] mode;
    logic [3:0]  group;
    logic        group_valid;
    scd_res_t    result;
    logic [4:0]  frame_len;
    logic        done;
    logic [31:0] reply_lo;
    logic [15:0] reply_hi;
    logic [47:0] latch_pos;
    logic        latch_prev;
    logic        ev_stat_clr;
    logic        ev_alm_hist;
    logic        ev_alm_rst;
    logic        ev_param;
    logic        ev_in_dev;
    logic [7:0]  ev_index;
    logic [31:0] ev_data;
  } scd_state_t;

endpackage
`default_nettype wire

// ---- scd_regs.svh ----
// Register offsets, field positions, command codes and constants of the servo command decoder
`ifndef SCD_REGS_SVH
`define SCD_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define SCD_OFF_CMD       8'h00
`define SCD_OFF_DATA      8'h04
`define SCD_OFF_MODE      8'h08
`define SCD_OFF_STATUS    8'h0C
`define SCD_OFF_REPLY_LO  8'h10
`define SCD_OFF_REPLY_HI  8'h14

// ****************************************
// Field positions
// ****************************************
`define SCD_CMD_CODE      7:0
`define SCD_CMD_DNO       15:8
`define SCD_MODE_PROG     0
`define SCD_MODE_TEST     6:4
`define SCD_MODE_STORED   9:8
`define SCD_MODE_UNIT     13:12
`define SCD_MODE_UNIT_DIS 14

// ****************************************
// Command codes and data numbers
// ****************************************
`define SCD_C_PT_POS    8'h40
`define SCD_C_PT_MCODE  8'h45
`define SCD_C_PT_SPEED  8'h50
`define SCD_C_PT_ACC    8'h54
`define SCD_C_PT_DEC    8'h58
`define SCD_C_PT_DWELL  8'h60
`define SCD_C_PT_AUX    8'h64
`define SCD_C_UNIT      8'h6C
`define SCD_C_GP_R      8'h6D
`define SCD_C_GP_D      8'h6E
`define SCD_C_GP_NUM    8'h6F
`define SCD_C_OTHERS    8'h00
`define SCD_C_ABS       8'h02
`define SCD_C_STAT_CLR  8'h81
`define SCD_C_ALARM     8'h82
`define SCD_C_GROUP     8'h85
`define SCD_C_IN_DEV    8'h92
`define SCD_C_PARAM     8'h94
`define SCD_D_00        8'h00
`define SCD_D_01        8'h01
`define SCD_D_PT_LAST   8'h1F
`define SCD_D_GP_LAST   8'h04
`define SCD_D_TEST      8'h12
`define SCD_D_STORED    8'h1D
`define SCD_D_CTRL      8'h1E
`define SCD_D_ABS_PLS   8'h90
`define SCD_D_ABS_CMD   8'h91
`define SCD_D_ALM_HIST  8'h20
`define SCD_D_IN_FIRST  8'h60
`define SCD_D_IN_LAST   8'h62
`define SCD_D_PARAM_LAST 8'hFF

// ****************************************
// Values
// ****************************************
`define SCD_KEY         32'h00001EA5
`define SCD_GRP_LAST    32'h00000005
`define SCD_GRP_POS     32'h0000000C
`define SCD_GP_COUNT    32'h00000004
`define SCD_CTRL_PT     32'h00000006
`define SCD_CTRL_PROG   32'h00000007
`define SCD_LEN_4       5'h04
`define SCD_LEN_8       5'h08
`define SCD_LEN_12      5'h0C
`define SCD_RESP_OKAY   2'h0
`define SCD_RESP_SLVERR 2'h2

`endif

// ---- test_scd_decoder.sv ----
// Self-checking testbench of the servo link command decoder
`timescale 1ns/100ps
`default_nettype none
`include "scd_regs.svh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
  $display("Error %0t: got %h expected %h", $time, a, b); end end

module test_scd_decoder;
  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic              aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]        s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [2:0]        s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0]       s_axi_wdata = 32'h0, s_axi_rdata, ext_rd_data, current_position = 32'h0;
  logic [3:0]        s_axi_wstrb = 4'hF, param_group;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  scd_pkg::scd_ext_t ext_rd_kind;
  logic [4:0]        ext_rd_index;
  logic              latch_position_input = 1'b0, latch_position_instruction = 1'b0;
  logic              status_clear, alarm_history_clear, alarm_reset, param_write, input_dev_write;
  logic [7:0]        param_number, input_dev_number;
  logic [31:0]       param_value, input_dev_value, s, v;
  logic [1:0]        r;
  int                err_total = 0, n_tests = 0;
  int                ev [5] = '{0, 0, 0, 0, 0}; // Pulse counts per event output

  scd_decoder scd_decoder_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ext_rd_kind, .ext_rd_index,
    .ext_rd_data, .current_position, .latch_position_input, .latch_position_instruction,
    .status_clear, .alarm_history_clear, .alarm_reset, .param_write, .param_group, .param_number,
    .param_value, .input_dev_write, .input_dev_number, .input_dev_value);
  scd_lookup_model scd_lookup_model_inst (.kind(ext_rd_kind), .index(ext_rd_index), .data(ext_rd_data));

  // ****************************************
  // Clock, pulse counting, watchdog
  // ****************************************
  initial forever #4 aclk = ~aclk;
  // Pulses last one cycle, so counting them catches doubles and misses
  always @(posedge aclk)
    if (aresetn)
    begin
      ev[0] += alarm_reset;
      ev[1] += alarm_history_clear;
      ev[2] += status_clear;
      ev[3] += param_write;
      ev[4] += input_dev_write;
    end
  initial
  begin
    repeat (20000) @(posedge aclk);
    err_total++;
    end_of_test();
  end

  // ****************************************
  // Bus tasks
  // ****************************************
  // Ready is sampled before the edge so the release follows the taking edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge aclk); // Edge between calls, so bready is never set and cleared in one step
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    forever
    begin
      @(negedge aclk); ha = s_axi_awvalid & s_axi_awready; hw = s_axi_wvalid & s_axi_wready; hb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ha) s_axi_awvalid <= 1'b0;
      if (hw) s_axi_wvalid <= 1'b0;
      if (hb)
      begin
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    logic ha, hr;
    @(posedge aclk); // Edge between calls, so rready is never set and cleared in one step
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    forever
    begin
      @(negedge aclk); ha = s_axi_arvalid & s_axi_arready; hr = s_axi_rvalid; d = s_axi_rdata; r = s_axi_rresp;
      @(posedge aclk);
      if (ha) s_axi_arvalid <= 1'b0;
      if (hr)
      begin
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
  // Data word, then command, then poll for done
  task automatic run(input logic [7:0] c, input logic [7:0] n, input logic [31:0] d);
    axi_wr(`SCD_OFF_DATA, d);
    axi_wr(`SCD_OFF_CMD, {16'h0000, n, c});
    for (int t = 0; t < 50; t++)
    begin
      axi_rd(`SCD_OFF_STATUS, s);
      if (s[1] === 1'b1) break;
    end
    `CHK(s[1], 1'b1)
    axi_rd(`SCD_OFF_REPLY_LO, v);
  endtask
  function automatic logic [31:0] ex(input scd_pkg::scd_ext_t k, input logic [4:0] i);
    return {8'hC3, 4'(k), 15'h0000, i};
  endfunction
  task automatic end_of_test();
    $display("Mismatches %0d of %0d checks", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  logic [7:0] cd [6] = '{8'h40, 8'h50, 8'h54, 8'h58, 8'h60, 8'h64};
  scd_pkg::scd_ext_t kd [6] = '{scd_pkg::SCD_EXT_PT_POS, scd_pkg::SCD_EXT_PT_SPEED, scd_pkg::SCD_EXT_PT_ACC,
    scd_pkg::SCD_EXT_PT_DEC, scd_pkg::SCD_EXT_PT_DWELL, scd_pkg::SCD_EXT_PT_AUX};
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    run(8'h94, 8'h01, 32'h5); `CHK(s[6:4], 3'h6)
    run(8'h85, 8'h00, 32'h6); `CHK(s[6:4], 3'h3)
    run(8'h85, 8'h00, 32'hC); `CHK(s[23:20], 4'hC)
    run(8'h94, 8'hFF, 32'h1234); `CHK({param_group, param_number, param_value}, {4'hC, 8'hFF, 32'h1234})
    `CHK(s[12:8], `SCD_LEN_12)
    foreach (cd[i])
    begin
      run(cd[i], 8'h1F, 32'h0); `CHK(v, ex(kd[i], 5'h1F))
      `CHK(s[12:8], `SCD_LEN_8)
    end
    run(8'h50, 8'h20, 32'h0); `CHK(s[6:4], 3'h3)
    run(8'h45, 8'h01, 32'h0); `CHK(s[6:4], 3'h5)
    run(8'h33, 8'h00, 32'h0); `CHK(s[6:4], 3'h4)
    axi_wr(`SCD_OFF_MODE, 32'h7250);
    run(8'h6C, 8'h00, 32'h0); `CHK(s[12:8], `SCD_LEN_4)
    `CHK(v, 32'h13)
    run(8'h6C, 8'h01, 32'h0); `CHK(s[6:4], 3'h1)
    run(8'h00, 8'h12, 32'h0); `CHK(v, 32'h5)
    run(8'h00, 8'h1D, 32'h0); `CHK(v, 32'h2)
    run(8'h00, 8'h1E, 32'h0); `CHK(v, `SCD_CTRL_PT)
    run(8'h6D, 8'h02, 32'h0); `CHK(s[6:4], 3'h1)
    axi_wr(`SCD_OFF_MODE, 32'h7251);
    run(8'h40, 8'h01, 32'h0); `CHK(s[6:4], 3'h1)
    run(8'h6D, 8'h02, 32'h0); `CHK(v, ex(scd_pkg::SCD_EXT_GP_R, 5'h02))
    run(8'h6E, 8'h04, 32'h0); `CHK(v, ex(scd_pkg::SCD_EXT_GP_D, 5'h04))
    run(8'h6F, 8'h01, 32'h0); `CHK(v, `SCD_GP_COUNT)
    run(8'h00, 8'h1E, 32'h0); `CHK(v, `SCD_CTRL_PROG)
    run(8'h02, 8'h90, 32'h0); `CHK(v, ex(scd_pkg::SCD_EXT_ABS_PLS, 5'h10))
    run(8'h02, 8'h91, 32'h0); `CHK(v, ex(scd_pkg::SCD_EXT_ABS_CMD, 5'h11))
    current_position <= 32'h80000001;
    latch_position_instruction <= 1'b1;
    @(posedge aclk);
    latch_position_input <= 1'b1;
    @(posedge aclk);
    current_position <= 32'h00000007;
    run(8'h6C, 8'h01, 32'h0); `CHK(v, 32'h80000001)
    axi_rd(`SCD_OFF_REPLY_HI, v); `CHK(v[15:0], 16'hFFFF)
    run(8'h82, 8'h00, 32'h1EA4); `CHK(s[6:4], 3'h2)
    run(8'h82, 8'h00, `SCD_KEY);
    run(8'h82, 8'h20, `SCD_KEY);
    run(8'h81, 8'h00, `SCD_KEY);
    run(8'h92, 8'h62, 32'hAB); `CHK({input_dev_number, input_dev_value}, {8'h62, 32'hAB})
    `CHK({ev[0], ev[1], ev[2], ev[3], ev[4]}, {32'd1, 32'd1, 32'd1, 32'd1, 32'd1})
    axi_wr(8'h20, 32'h0); `CHK(r, `SCD_RESP_SLVERR)
    axi_rd(8'h20, v); `CHK(r, `SCD_RESP_SLVERR)
    end_of_test();
  end
endmodule
`default_nettype wire
